// File: hdl/sfs_pkg.sv
/*
  Constants shared by the servo fault supervisor: register offsets,
  reset values, fault bit positions, fault codes and input function
  numbers. Assumes a 32-bit classic Wishbone register bus.
*/
package sfs_pkg;

  // --------------------------------------------------------------
  // Register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_OVERSPEED = 8'h04;
  localparam logic [7:0] REG_POS_THRESHOLD = 8'h08;
  localparam logic [7:0] REG_RATED_SPEED = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_FAULT_CODE = 8'h18;
  localparam logic [7:0] REG_DETECTED = 8'h1C;
  localparam logic [7:0] REG_TERM_BASE = 8'h20;
  localparam logic [7:0] REG_TERM_LAST = 8'h2C;

  // --------------------------------------------------------------
  // Control fields and reset values
  // --------------------------------------------------------------
  localparam int CTRL_HOMING_SWITCH_BIT = 0;
  localparam int CTRL_FIXED_LENGTH_BIT = 1;
  localparam int CTRL_ENC_TYPE_LSB = 4;
  localparam int ENC_TYPE_WIDTH = 4;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [15:0] OVERSPEED_RESET = 16'h0078;
  localparam logic [31:0] POS_THRESHOLD_RESET = 32'h0000_2710;
  localparam logic [15:0] RATED_SPEED_RESET = 16'h0BB8;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam logic [15:0] PERCENT_SCALE = 16'h0064;

  // --------------------------------------------------------------
  // Terminals: 8 physical then 8 virtual, one function byte each
  // --------------------------------------------------------------
  localparam int TERM_COUNT = 16;
  localparam int TERMS_PER_WORD = 4;
  localparam logic [7:0] FUNC_NONE = 8'h00;
  localparam logic [7:0] FUNC_ORIGIN_SWITCH = 8'h22;
  localparam logic [7:0] FUNC_FIXED_LENGTH_TRIGGER = 8'h28;

  // --------------------------------------------------------------
  // Fault bits, lowest code first, and their numeric codes
  // --------------------------------------------------------------
  localparam int FAULT_COUNT = 7;
  localparam int FB_HALL = 0;
  localparam int FB_ENC_TYPE = 1;
  localparam int FB_ORIGIN = 2;
  localparam int FB_DUP = 3;
  localparam int FB_OVERSPEED = 4;
  localparam int FB_POS_ERR = 5;
  localparam int FB_FIXED_LEN = 6;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_HALL = 8'h76;
  localparam logic [7:0] CODE_ENC_TYPE = 8'h77;
  localparam logic [7:0] CODE_ORIGIN = 8'hC8;
  localparam logic [7:0] CODE_DUP = 8'hC9;
  localparam logic [7:0] CODE_OVERSPEED = 8'hCA;
  localparam logic [7:0] CODE_POS_ERR = 8'hCB;
  localparam logic [7:0] CODE_FIXED_LEN = 8'hCC;

  localparam logic [2:0] HALL_ALL_LOW = 3'h0;
  localparam logic [2:0] HALL_ALL_HIGH = 3'h7;

endpackage : sfs_pkg

// File: hdl/sfs_map_check.sv
/*
  Checks the input function assignment of all terminals: finds any
  function mapped twice and whether the origin switch and fixed-length
  trigger functions are mapped at all. Purely combinational.
*/
`timescale 1ns/100ps
module sfs_map_check
  import sfs_pkg::*;
(
  // Packed function numbers, terminal 0 in the low byte
  input wire logic [8*TERM_COUNT-1:0] term_funcs_i,
  // Results
  output logic duplicate_o,
  output logic origin_mapped_o,
  output logic trigger_mapped_o
);

  logic [7:0] func_a;
  logic [7:0] func_b;

  always_comb begin
    duplicate_o = 1'b0;
    origin_mapped_o = 1'b0;
    trigger_mapped_o = 1'b0;
    func_a = FUNC_NONE;
    func_b = FUNC_NONE;
    for (int i = 0; i < TERM_COUNT; i++) begin
      func_a = term_funcs_i[8*i +: 8];
      if (func_a == FUNC_ORIGIN_SWITCH) begin
        origin_mapped_o = 1'b1;
      end
      if (func_a == FUNC_FIXED_LENGTH_TRIGGER) begin
        trigger_mapped_o = 1'b1;
      end
      // Physical and virtual terminals share one function space
      for (int j = i + 1; j < TERM_COUNT; j++) begin
        func_b = term_funcs_i[8*j +: 8];
        if (func_a != FUNC_NONE && func_a == func_b) begin
          duplicate_o = 1'b1;
        end
      end
    end
  end

endmodule : sfs_map_check

// File: hdl/sfs_supervisor.sv
/*
  Servo fault supervisor: checks encoder feedback and configuration,
  latches fault bits, reports the lowest active fault code and raises
  an interrupt. Assumes a classic Wishbone master on clk_i and
  encoder/position inputs synchronous to clk_i.
*/
// Notes on behaviour
// R1 - At power-up, an all-low or all-high Hall code raises 118.
// R2 - Detected encoder type differing from configured type raises 119.
// R3 - Homing needing origin switch with function 34 unmapped raises 200.
// R4 - Any function number mapped to two terminals raises 201.
// R5 - Speed over rated speed above percent limit raises 202.
// R6 - Position error magnitude above threshold raises 203.
// R7 - Fixed-length enabled with function 40 unmapped raises 204.
// R8 - Faults latch until cleared; lowest active code is reported.
`timescale 1ns/100ps
module sfs_supervisor
  import sfs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Encoder and position feedback
  input wire logic hall_valid_i,
  input wire logic [2:0] hall_code_i,
  input wire logic [ENC_TYPE_WIDTH-1:0] enc_type_detected_i,
  input wire logic signed [15:0] actual_speed_i,
  input wire logic signed [31:0] cmd_position_i,
  input wire logic signed [31:0] act_position_i,
  // Fault report
  output logic [7:0] fault_code_o,
  output logic irq_o
);

  // --------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic [7:0] lowest_code(input logic [6:0] bits);
    logic [7:0] code;
    code = CODE_NONE;
    if (bits[FB_HALL]) code = CODE_HALL;
    else if (bits[FB_ENC_TYPE]) code = CODE_ENC_TYPE;
    else if (bits[FB_ORIGIN]) code = CODE_ORIGIN;
    else if (bits[FB_DUP]) code = CODE_DUP;
    else if (bits[FB_OVERSPEED]) code = CODE_OVERSPEED;
    else if (bits[FB_POS_ERR]) code = CODE_POS_ERR;
    else if (bits[FB_FIXED_LEN]) code = CODE_FIXED_LEN;
    return code;
  endfunction : lowest_code

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  logic [31:0] control;
  logic [15:0] overspeed_percent_limit;
  logic [31:0] position_error_threshold;
  logic [15:0] rated_speed;
  logic [6:0] status;
  logic [6:0] mask;
  logic [7:0] term_func [0:TERM_COUNT-1];
  logic hall_checked;

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_write = bus_req & wb_we_i & wb_ack_o;
  wire [7:0] word_adr = {wb_adr_i[7:2], 2'b00};
  wire hit_term = word_adr >= REG_TERM_BASE && word_adr <= REG_TERM_LAST;
  wire [1:0] term_word = 2'(wb_adr_i[7:2] - REG_TERM_BASE[7:2]);
  wire [31:0] term_rd = {term_func[4*term_word + 3],
                         term_func[4*term_word + 2],
                         term_func[4*term_word + 1],
                         term_func[4*term_word]};
  wire [31:0] term_wr = merge_bytes(term_rd, wb_dat_i, wb_sel_i);
  wire [6:0] status_clear = (bus_write && word_adr == REG_STATUS) ?
                            wb_dat_i[6:0] & {7{wb_sel_i[0]}} : 7'h00;

  logic [31:0] read_mux;
  always_comb begin
    if (word_adr == REG_CONTROL) read_mux = control;
    else if (word_adr == REG_OVERSPEED) read_mux = {16'h0000,
                                                    overspeed_percent_limit};
    else if (word_adr == REG_POS_THRESHOLD)
      read_mux = position_error_threshold;
    else if (word_adr == REG_RATED_SPEED) read_mux = {16'h0000, rated_speed};
    else if (word_adr == REG_STATUS) read_mux = {25'h0, status};
    else if (word_adr == REG_MASK) read_mux = {25'h0, mask};
    else if (word_adr == REG_FAULT_CODE) read_mux = {24'h0, fault_code_o};
    else if (word_adr == REG_DETECTED)
      read_mux = {28'h0, enc_type_detected_i};
    else if (hit_term) read_mux = term_rd;
    else read_mux = 32'h0000_0000;
  end

  // --------------------------------------------------------------
  // Fault detection
  // --------------------------------------------------------------
  logic [8*TERM_COUNT-1:0] term_packed;
  always_comb begin
    for (int t = 0; t < TERM_COUNT; t++) begin
      term_packed[8*t +: 8] = term_func[t];
    end
  end

  logic map_duplicate;
  logic origin_mapped;
  logic trigger_mapped;

  sfs_map_check u_map_check (
    .term_funcs_i(term_packed),
    .duplicate_o(map_duplicate),
    .origin_mapped_o(origin_mapped),
    .trigger_mapped_o(trigger_mapped)
  );

  wire [15:0] speed_mag = actual_speed_i[15] ? 16'(-actual_speed_i) :
                          16'(actual_speed_i);
  wire [31:0] speed_scaled = speed_mag * PERCENT_SCALE;
  wire [31:0] speed_limit = overspeed_percent_limit * rated_speed;
  wire signed [32:0] pos_diff = 33'(cmd_position_i) - 33'(act_position_i);
  wire [32:0] pos_mag = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
  wire [ENC_TYPE_WIDTH-1:0] enc_type_setting =
    control[CTRL_ENC_TYPE_LSB +: ENC_TYPE_WIDTH];

  wire hall_bad = hall_code_i == HALL_ALL_LOW ||
                  hall_code_i == HALL_ALL_HIGH;
  wire [6:0] fault_event;
  assign fault_event[FB_HALL] = hall_valid_i & ~hall_checked & hall_bad; // R1
  assign fault_event[FB_ENC_TYPE] =
    enc_type_detected_i != enc_type_setting; // R2
  assign fault_event[FB_ORIGIN] =
    control[CTRL_HOMING_SWITCH_BIT] & ~origin_mapped; // R3
  assign fault_event[FB_DUP] = map_duplicate; // R4
  assign fault_event[FB_OVERSPEED] = speed_scaled > speed_limit; // R5
  assign fault_event[FB_POS_ERR] =
    pos_mag > {1'b0, position_error_threshold}; // R6
  assign fault_event[FB_FIXED_LEN] =
    control[CTRL_FIXED_LENGTH_BIT] & ~trigger_mapped; // R7

  // Set wins over a clear written in the same cycle
  wire [6:0] next_status = (status & ~status_clear) | fault_event; // R8
  wire [7:0] next_fault_code = lowest_code(next_status); // R8
  wire next_irq = |(next_status & mask);

  // --------------------------------------------------------------
  // Sequential logic
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= (bus_req & ~wb_we_i & ~wb_ack_o) ? read_mux :
                  32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status <= 7'h00;
      fault_code_o <= CODE_NONE;
      irq_o <= 1'b0;
      hall_checked <= 1'b0;
    end else begin
      status <= next_status;
      fault_code_o <= next_fault_code;
      irq_o <= next_irq;
      hall_checked <= hall_checked | hall_valid_i; // R1
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control <= CONTROL_RESET;
      overspeed_percent_limit <= OVERSPEED_RESET;
      position_error_threshold <= POS_THRESHOLD_RESET;
      rated_speed <= RATED_SPEED_RESET;
      mask <= MASK_RESET;
    end else if (bus_write) begin
      if (word_adr == REG_CONTROL)
        control <= merge_bytes(control, wb_dat_i, wb_sel_i);
      else if (word_adr == REG_OVERSPEED)
        overspeed_percent_limit <= 16'(merge_bytes(
          {16'h0000, overspeed_percent_limit}, wb_dat_i, wb_sel_i));
      else if (word_adr == REG_POS_THRESHOLD)
        position_error_threshold <= merge_bytes(position_error_threshold,
                                                wb_dat_i, wb_sel_i);
      else if (word_adr == REG_RATED_SPEED)
        rated_speed <= 16'(merge_bytes({16'h0000, rated_speed},
                                       wb_dat_i, wb_sel_i));
      else if (word_adr == REG_MASK && wb_sel_i[0])
        mask <= wb_dat_i[6:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int t = 0; t < TERM_COUNT; t++) begin
        term_func[t] <= FUNC_NONE;
      end
    end else if (bus_write && hit_term) begin
      for (int k = 0; k < TERMS_PER_WORD; k++) begin
        term_func[4*term_word + k] <= term_wr[8*k +: 8];
      end
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_hall_powerup: assert property ( // R1
    @(posedge clk_i) disable iff (!reset_n_i)
    hall_valid_i && !hall_checked && hall_bad |=> status[FB_HALL])
    else $error("bad power-up hall code not latched");

  a_hall_once: assert property ( // R1
    @(posedge clk_i) disable iff (!reset_n_i)
    hall_checked && !status[FB_HALL] && status_clear == 7'h00
    |=> !status[FB_HALL])
    else $error("hall fault raised after power-up check");

  a_enc_mismatch: assert property ( // R2
    @(posedge clk_i) disable iff (!reset_n_i)
    enc_type_detected_i != control[CTRL_ENC_TYPE_LSB +: ENC_TYPE_WIDTH]
    |=> status[FB_ENC_TYPE])
    else $error("encoder type mismatch not latched");

  a_origin_missing: assert property ( // R3
    @(posedge clk_i) disable iff (!reset_n_i)
    control[CTRL_HOMING_SWITCH_BIT] && !origin_mapped |=> status[FB_ORIGIN])
    else $error("missing origin switch not latched");

  a_dup_function: assert property ( // R4
    @(posedge clk_i) disable iff (!reset_n_i)
    map_duplicate |=> status[FB_DUP])
    else $error("duplicated input function not latched");

  a_overspeed_trip: assert property ( // R5
    @(posedge clk_i) disable iff (!reset_n_i)
    32'(speed_mag) * 32'(PERCENT_SCALE) >
    32'(overspeed_percent_limit) * 32'(rated_speed)
    |=> status[FB_OVERSPEED])
    else $error("overspeed not latched");

  a_pos_err_trip: assert property ( // R6
    @(posedge clk_i) disable iff (!reset_n_i)
    !status[FB_POS_ERR] && pos_mag > {1'b0, position_error_threshold}
    |=> status[FB_POS_ERR] ##1
    (status[FB_POS_ERR] || $past(status_clear[FB_POS_ERR])))
    else $error("position error not latched");

  a_fixed_missing: assert property ( // R7
    @(posedge clk_i) disable iff (!reset_n_i)
    control[CTRL_FIXED_LENGTH_BIT] && !trigger_mapped
    |=> status[FB_FIXED_LEN])
    else $error("missing fixed-length trigger not latched");

  a_fault_hold: assert property ( // R8
    @(posedge clk_i) disable iff (!reset_n_i)
    status[FB_DUP] && !status_clear[FB_DUP] |=> status[FB_DUP])
    else $error("fault dropped without clear");

  a_code_lowest: assert property ( // R8
    @(posedge clk_i) disable iff (!reset_n_i)
    status[FB_HALL] |-> fault_code_o == CODE_HALL)
    else $error("lowest fault code not reported");

  a_code_next: assert property ( // R8
    @(posedge clk_i) disable iff (!reset_n_i)
    !status[FB_HALL] && status[FB_ENC_TYPE]
    |-> fault_code_o == CODE_ENC_TYPE)
    else $error("encoder fault code not reported first");

  a_code_none: assert property ( // R8
    @(posedge clk_i) disable iff (!reset_n_i)
    status == 7'h00 |-> fault_code_o == CODE_NONE)
    else $error("fault code shown with no fault latched");

  a_irq_level: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ##1 irq_o == |($past(next_status) & $past(mask)))
    else $error("interrupt does not follow masked status");

endmodule : sfs_supervisor

// File: testbench/sfs_enc_model.sv
/*
  Far-side model: motor encoder and position feedback source.
  Assumes the bench sets the wanted values; they reach the
  supervisor one clock edge later.
*/
`timescale 1ns/100ps
module sfs_enc_model
  import sfs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Wanted feedback
  input wire logic hall_valid_req_i,
  input wire logic [2:0] hall_code_req_i,
  input wire logic [ENC_TYPE_WIDTH-1:0] enc_type_req_i,
  input wire logic signed [15:0] speed_req_i,
  input wire logic signed [31:0] cmd_req_i,
  input wire logic signed [31:0] act_req_i,
  // Feedback to the supervisor
  output logic hall_valid_o,
  output logic [2:0] hall_code_o,
  output logic [ENC_TYPE_WIDTH-1:0] enc_type_o,
  output logic signed [15:0] speed_o,
  output logic signed [31:0] cmd_o,
  output logic signed [31:0] act_o
);
  // Hall lines are meaningless outside a valid cycle, so they wander
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hall_valid_o <= 1'b0;
      hall_code_o <= 3'h5;
      enc_type_o <= '0;
      speed_o <= 16'sh0000;
      cmd_o <= 32'sh0000_0000;
      act_o <= 32'sh0000_0000;
    end else begin
      hall_valid_o <= hall_valid_req_i;
      hall_code_o <= hall_valid_req_i ? hall_code_req_i : ~hall_code_o;
      enc_type_o <= enc_type_req_i;
      speed_o <= speed_req_i;
      cmd_o <= cmd_req_i;
      act_o <= act_req_i;
    end
  end
endmodule : sfs_enc_model

// File: testbench/tb_top.sv
/*
  Self-checking bench for the servo fault supervisor. Assumes the
  supervisor answers on classic Wishbone and the encoder model feeds it.
*/
`timescale 1ns/100ps
module tb_top
  import sfs_pkg::*;
;
  logic clk_i, reset_n_i, cyc, stb, we, ack, irq, hv;
  logic [7:0] adr, code;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, lf;
  logic [2:0] hc, hcm;
  logic [3:0] et, etm;
  logic signed [15:0] spd, spdm, sv;
  logic signed [31:0] cmd, act, cmdm, actm;
  logic hvm;
  logic [6:0] mask;
  int n_fail, check_count, cyc_n;
  logic [31:0] q;
  localparam logic [7:0] CODES [7] = '{CODE_HALL, CODE_ENC_TYPE,
    CODE_ORIGIN, CODE_DUP, CODE_OVERSPEED, CODE_POS_ERR, CODE_FIXED_LEN};
  localparam int POS_LIM = int'(POS_THRESHOLD_RESET);

  sfs_enc_model enc_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .hall_valid_req_i(hv), .hall_code_req_i(hc), .enc_type_req_i(et),
    .speed_req_i(spd), .cmd_req_i(cmd), .act_req_i(act),
    .hall_valid_o(hvm), .hall_code_o(hcm), .enc_type_o(etm),
    .speed_o(spdm), .cmd_o(cmdm), .act_o(actm));

  sfs_supervisor dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .hall_valid_i(hvm), .hall_code_i(hcm), .enc_type_detected_i(etm),
    .actual_speed_i(spdm), .cmd_position_i(cmdm),
    .act_position_i(actm), .fault_code_o(code), .irq_o(irq));

  always #25 clk_i = ~clk_i;

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n >= 20000) begin
      n_fail++;
      end_sim();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] code_of(input logic [6:0] st);
    for (int i = 0; i < FAULT_COUNT; i++)
      if (st[i])
        return CODES[i];
    return CODE_NONE;
  endfunction : code_of

  function automatic logic over(input int s);
    int a;
    a = (s < 0) ? -s : s;
    return a * int'(PERCENT_SCALE) >
      int'(OVERSPEED_RESET) * int'(RATED_SPEED_RESET);
  endfunction : over

  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'h0000_0000, 32'h0000_0001);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rd

  // Latched status, reported code and interrupt level together
  task automatic fault(input logic [6:0] st);
    repeat (3) @(posedge clk_i);
    chk({24'h0, code}, {24'h0, code_of(st)});
    chk({31'h0, irq}, {31'h0, |(st & mask)});
    rd(REG_STATUS, {25'h0, st});
  endtask : fault

  task automatic clr_chk(input logic [6:0] st);
    wr(REG_STATUS, 32'h0000_007F);
    fault(st);
  endtask : clr_chk

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 0; reset_n_i = 0; cyc = 0; stb = 0; we = 0; adr = 8'h00;
    sel = 4'h0; dat = 32'h0; hv = 0; hc = 3'h5; et = 4'h0; spd = 0;
    cmd = 0; act = 0; mask = 7'h00; n_fail = 0; check_count = 0;
    cyc_n = 0; lf = 32'h8A0D;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(REG_CONTROL, CONTROL_RESET);
    rd(REG_OVERSPEED, {16'h0, OVERSPEED_RESET});
    rd(REG_POS_THRESHOLD, POS_THRESHOLD_RESET);
    rd(REG_RATED_SPEED, {16'h0, RATED_SPEED_RESET});
    rd(REG_MASK, {25'h0, MASK_RESET});
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    wr(REG_FAULT_CODE, 32'h0000_00FF);
    rd(REG_FAULT_CODE, 32'h0000_0000);
    @(posedge clk_i);
    hc <= HALL_ALL_LOW;
    hv <= 1'b1;
    @(posedge clk_i);
    hv <= 1'b0;
    fault(7'h01);
    wr(REG_MASK, 32'h0000_007F);
    mask = 7'h7F;
    fault(7'h01);
    clr_chk(7'h00);
    et <= 4'h3;
    fault(7'h02);
    rd(REG_DETECTED, 32'h0000_0003);
    wr(REG_CONTROL, 32'h0000_0030);
    clr_chk(7'h00);
    wr(REG_CONTROL, 32'h0000_0031);
    fault(7'h04);
    wr(REG_TERM_BASE + 8'h04, 32'h0000_2200);
    clr_chk(7'h00);
    wr(REG_TERM_LAST, 32'h0000_0022);
    fault(7'h08);
    wr(REG_TERM_LAST, 32'h0000_0000);
    clr_chk(7'h00);
    wr(REG_CONTROL, 32'h0000_0033);
    fault(7'h40);
    wr(REG_TERM_BASE, 32'h0000_0028);
    clr_chk(7'h00);
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      sv = (i < 4) ? ((i % 2) ? 16'sd3601 : 16'sd3600) :
        16'(3000 + lf[15:0] % 1200);
      if (i % 4 >= 2 || lf[20])
        sv = -sv;
      spd <= sv;
      @(posedge clk_i);
      fault(over(int'(spd)) ? 7'h10 : 7'h00);
      spd <= 16'sd0;
      clr_chk(7'h00);
    end
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      cmd <= 32'(lf[23:0]);
      act <= 32'(lf[23:0]) - ((i < 4) ? ((i % 2) ? 10001 : 10000) *
        ((i < 2) ? 1 : -1) : int'(lf[31:8] % 20004) - 10002);
      @(posedge clk_i);
      fault((cmd - act > POS_LIM || act - cmd > POS_LIM) ? 7'h20 : 7'h00);
      act <= cmd;
      clr_chk(7'h00);
    end
    spd <= 16'sd4000;
    act <= cmd + 20000;
    fault(7'h30);
    clr_chk(7'h30);
    spd <= 16'sd0;
    act <= cmd;
    wr(REG_MASK, 32'h0000_0010);
    mask = 7'h10;
    wr(REG_STATUS, 32'h0000_0010);
    fault(7'h20);
    clr_chk(7'h00);
    // Second reset in mid-run re-arms the power-up hall check
    et <= 4'h0;
    reset_n_i <= 1'b0;
    mask = 7'h00;
    @(posedge clk_i);
    @(posedge clk_i);
    chk({23'h0, irq, code}, 32'h0000_0000);
    reset_n_i <= 1'b1;
    hc <= HALL_ALL_HIGH;
    hv <= 1'b1;
    @(posedge clk_i);
    hv <= 1'b0;
    fault(7'h01);
    clr_chk(7'h00);
    end_sim();
  end
endmodule : tb_top
